/* design/pin_mux_pkg.sv */
`default_nettype none
package pin_mux_pkg;
  // pin indices inside the shared group
  localparam int unsigned PIN_MISO  = 0; // port_b_pin_2
  localparam int unsigned PIN_MOSI  = 1; // port_b_pin_3
  localparam int unsigned PIN_PULSE_WIDTH_OUTPUT_0  = 2; // port_a_pin_0
  localparam int unsigned PIN_COUNT = 3;

  // function select codes per pin
  typedef enum logic [1:0] {
    FUNC_PORT   = 2'h0,
    FUNC_SPI    = 2'h1,
    FUNC_TIMER  = 2'h2,
    FUNC_PWM    = 2'h3
  } pin_func_t;

  // reset values: port function, input direction, data low
  localparam pin_func_t RESET_FUNC = FUNC_PORT;
  localparam logic      RESET_DIR  = 1'h0;
  localparam logic      RESET_DATA = 1'h0;
endpackage
`default_nettype wire

/* design/port_pin_function_select.sv */
// Overview of operation
// - each port pin individually input or output
// - miso pin resets to port function
// - mosi pin resets to port function
// - pulse_width_output_0 pin resets to port function
// - integration unit picks peripheral function
// - miso input as master, output as slave
// - unselected slave floats miso
`default_nettype none
module port_pin_function_select
  import pin_mux_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  // port data/direction from software-visible port logic
  input  wire logic [2:0]             port_dir,
  input  wire logic [2:0]             port_data,
  // function selects from system_integration_unit
  input  wire pin_mux_pkg::pin_func_t sel_b2,
  input  wire pin_mux_pkg::pin_func_t sel_b3,
  input  wire pin_mux_pkg::pin_func_t sel_a0,
  // spi peripheral side
  input  wire logic                   spi_master,
  input  wire logic                   spi_ss_n,
  input  wire logic                   spi_miso_out,
  input  wire logic                   spi_mosi_out,
  output logic                        spi_miso_in,
  output logic                        spi_mosi_in,
  // timer and pwm side
  input  wire logic                   timer_channel_2_out,
  input  wire logic                   timer_channel_2_oe,
  input  wire logic                   timer_channel_3_out,
  input  wire logic                   timer_channel_3_oe,
  input  wire logic                   pulse_width_output_0,
  output logic                        timer_channel_2_in,
  output logic                        timer_channel_3_in,
  // pins: input, output, output enable; registered copy of pin input for the port
  input  wire logic [2:0]             pin_in,
  output logic      [2:0]             pin_out,
  output logic      [2:0]             pin_oe,
  output logic      [2:0]             port_in
);
  import pin_mux_pkg::*;

  pin_func_t  func [PIN_COUNT];
  pin_func_t  next_func [PIN_COUNT];
  logic [2:0] next_out;
  logic [2:0] next_oe;
  logic [2:0] next_port_in;
  logic [2:0] next_periph_in;
  logic [2:0] periph_in;

  // latch selects; illegal pin/function pairs fall back to port
  always_comb begin
    next_func[PIN_MISO] = (sel_b2 == FUNC_SPI || sel_b2 == FUNC_TIMER)
                          ? sel_b2 : FUNC_PORT;
    next_func[PIN_MOSI] = (sel_b3 == FUNC_SPI || sel_b3 == FUNC_TIMER)
                          ? sel_b3 : FUNC_PORT;
    next_func[PIN_PULSE_WIDTH_OUTPUT_0] = (sel_a0 == FUNC_PWM) ? FUNC_PWM : FUNC_PORT;
  end

  // drive selection per pin; registered so every output is a flop
  always_comb begin
    next_out = '0;
    next_oe  = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_out[i] = port_data[i];
      next_oe[i]  = port_dir[i];
    end
    unique case (func[PIN_MISO])
      FUNC_SPI: begin
        next_out[PIN_MISO] = spi_miso_out;
        next_oe[PIN_MISO]  = !spi_master && !spi_ss_n;
      end
      FUNC_TIMER: begin
        next_out[PIN_MISO] = timer_channel_2_out;
        next_oe[PIN_MISO]  = timer_channel_2_oe;
      end
      default: ;
    endcase
    unique case (func[PIN_MOSI])
      FUNC_SPI: begin
        next_out[PIN_MOSI] = spi_mosi_out;
        next_oe[PIN_MOSI]  = spi_master;
      end
      FUNC_TIMER: begin
        next_out[PIN_MOSI] = timer_channel_3_out;
        next_oe[PIN_MOSI]  = timer_channel_3_oe;
      end
      default: ;
    endcase
    if (func[PIN_PULSE_WIDTH_OUTPUT_0] == FUNC_PWM) begin
      next_out[PIN_PULSE_WIDTH_OUTPUT_0] = pulse_width_output_0;
      next_oe[PIN_PULSE_WIDTH_OUTPUT_0]  = 1'h1;
    end
    next_port_in   = pin_in;
    next_periph_in = pin_in;
  end

  // registers; reset leaves all pins as port inputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < PIN_COUNT; i++) func[i] <= RESET_FUNC;
      pin_out   <= {PIN_COUNT{RESET_DATA}};
      pin_oe    <= {PIN_COUNT{RESET_DIR}};
      port_in   <= '0;
      periph_in <= '0;
    end else begin
      func      <= next_func;
      pin_out   <= next_out;
      pin_oe    <= next_oe;
      port_in   <= next_port_in;
      periph_in <= next_periph_in;
    end
  end

  // peripheral inputs are flop copies; one extra cycle of latency
  assign spi_miso_in        = periph_in[PIN_MISO];
  assign spi_mosi_in        = periph_in[PIN_MOSI];
  assign timer_channel_2_in = periph_in[PIN_MISO];
  assign timer_channel_3_in = periph_in[PIN_MOSI];

  // assertions
  property p_reset_port;
    @(posedge core_clk) !nrst |=> (pin_oe == 3'h0); 
  endproperty
  a_reset_port: assert property (p_reset_port)
    else $error("pins not inputs after reset");

  property p_port_dir;
    @(posedge core_clk) disable iff (!nrst)
      (func[PIN_PULSE_WIDTH_OUTPUT_0] == FUNC_PORT) |=>
        (pin_oe[PIN_PULSE_WIDTH_OUTPUT_0] == $past(port_dir[PIN_PULSE_WIDTH_OUTPUT_0]));
  endproperty
  a_port_dir: assert property (p_port_dir)
    else $error("port direction not followed");

  property p_miso_float;
    @(posedge core_clk) disable iff (!nrst)
      (func[PIN_MISO] == FUNC_SPI && spi_ss_n) |=> !pin_oe[PIN_MISO];
  endproperty
  a_miso_float: assert property (p_miso_float)
    else $error("unselected slave drives miso");

  property p_miso_master_in;
    @(posedge core_clk) disable iff (!nrst)
      (func[PIN_MISO] == FUNC_SPI && spi_master) |=> !pin_oe[PIN_MISO];
  endproperty
  a_miso_master_in: assert property (p_miso_master_in)
    else $error("master drives miso");

  property p_mosi_master;
    @(posedge core_clk) disable iff (!nrst)
      (func[PIN_MOSI] == FUNC_SPI) |=>
        (pin_oe[PIN_MOSI] == $past(spi_master) &&
         pin_out[PIN_MOSI] == $past(spi_mosi_out));
  endproperty
  a_mosi_master: assert property (p_mosi_master)
    else $error("mosi not driven by master");

  property p_miso_data;
    @(posedge core_clk) disable iff (!nrst)
      (func[PIN_MISO] == FUNC_SPI) |=>
        (pin_out[PIN_MISO] == $past(spi_miso_out));
  endproperty
  a_miso_data: assert property (p_miso_data)
    else $error("miso data not from spi");

  property p_pwm_override;
    @(posedge core_clk) disable iff (!nrst)
      (func[PIN_PULSE_WIDTH_OUTPUT_0] == FUNC_PWM) |=>
        (pin_oe[PIN_PULSE_WIDTH_OUTPUT_0] && pin_out[PIN_PULSE_WIDTH_OUTPUT_0] == $past(pulse_width_output_0));
  endproperty
  a_pwm_override: assert property (p_pwm_override)
    else $error("pwm does not override port");

  property p_select;
    @(posedge core_clk) disable iff (!nrst)
      (sel_a0 == FUNC_PWM) |=> (func[PIN_PULSE_WIDTH_OUTPUT_0] == FUNC_PWM);
  endproperty
  a_select: assert property (p_select)
    else $error("select not taken");

  property p_reset_func;
    @(posedge core_clk) !nrst |=>
      (func[PIN_MISO] == FUNC_PORT && func[PIN_MOSI] == FUNC_PORT &&
       func[PIN_PULSE_WIDTH_OUTPUT_0] == FUNC_PORT);
  endproperty
  a_reset_func: assert property (p_reset_func)
    else $error("pin function not port after reset");

  property p_port_in;
    @(posedge core_clk) disable iff (!nrst)
      nrst |=> (port_in == $past(pin_in));
  endproperty
  a_port_in: assert property (p_port_in)
    else $error("port input not a copy of the pins");

  property p_timer_override;
    @(posedge core_clk) disable iff (!nrst)
      (func[PIN_MISO] == FUNC_TIMER) |=>
        (pin_oe[PIN_MISO] == $past(timer_channel_2_oe) &&
         pin_out[PIN_MISO] == $past(timer_channel_2_out));
  endproperty
  a_timer_override: assert property (p_timer_override)
    else $error("timer does not override port");

  property p_refuse;
    @(posedge core_clk) disable iff (!nrst)
      (sel_b3 == FUNC_PWM) |=> (func[PIN_MOSI] == FUNC_PORT);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("illegal select not refused");

  c_slave_drive: cover property (@(posedge core_clk)
    func[PIN_MISO] == FUNC_SPI && pin_oe[PIN_MISO]);
  c_timer2: cover property (@(posedge core_clk)
    func[PIN_MISO] == FUNC_TIMER);
  c_pwm: cover property (@(posedge core_clk) func[PIN_PULSE_WIDTH_OUTPUT_0] == FUNC_PWM);
  c_master_mosi: cover property (@(posedge core_clk)
    func[PIN_MOSI] == FUNC_SPI && pin_oe[PIN_MOSI]);
endmodule
`default_nettype wire

/* verification/spi_far_side.sv */
`default_nettype none
module spi_far_side (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic       ext_en,
  input  wire logic       ext_val,
  output logic      [2:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // released pins float up on their pull-ups, except pin 0 reads ext_val while ext_en is set
  always_comb begin
    pin_in = pin_out | ~pin_oe;
    if (ext_en && !pin_oe[0]) pin_in[0] = ext_val;
  end
endmodule
`default_nettype wire

/* verification/test_port_pin_function_select.sv */
`default_nettype none
module test_port_pin_function_select;
  timeunit 1ns;
  timeprecision 100ps;
  import pin_mux_pkg::*;
  // sp = {master, ss_n, miso_out, mosi_out, pwm}; tm = {t3oe,t3,t2oe,t2}
  typedef struct packed {
    pin_func_t  s2, s3, s0;
    logic [2:0] dir, dat;
    logic [4:0] sp;
    logic [3:0] tm;
    logic [2:0] oe, out;
  } row_t;
  // bench raises ss_n for an unselected slave
  row_t       rows [7] = '{
    '{FUNC_PORT, FUNC_PORT, FUNC_PORT, 3'h5, 3'h4, 5'h08, 4'h0, 3'h5, 3'h4},
    '{FUNC_PORT, FUNC_PORT, FUNC_PORT, 3'h2, 3'h2, 5'h08, 4'h0, 3'h2, 3'h2},
    '{FUNC_SPI, FUNC_SPI, FUNC_PWM, 3'h0, 3'h0, 5'h05, 4'h0, 3'h5, 3'h5},
    '{FUNC_SPI, FUNC_SPI, FUNC_PWM, 3'h7, 3'h0, 5'h0e, 4'h0, 3'h4, 3'h0},
    '{FUNC_SPI, FUNC_SPI, FUNC_PORT, 3'h0, 3'h0, 5'h1e, 4'h0, 3'h2, 3'h2},
    '{FUNC_TIMER, FUNC_TIMER, FUNC_SPI, 3'h4, 3'h4, 5'h08, 4'h7, 3'h5, 3'h5},
    '{FUNC_PWM, FUNC_PWM, FUNC_TIMER, 3'h1, 3'h0, 5'h08, 4'h0, 3'h1, 3'h0}};
  logic       core_clk = 1'h0;
  logic       nrst     = 1'h0;
  // far slave: drives a released miso when enabled, else released pins float up
  logic       far_en   = 1'h1;
  logic       far_val  = 1'h0;
  row_t       cur;
  logic [2:0] pin_in, pin_out, pin_oe, port_in, exp_in;
  logic       miso_in, mosi_in, tmr2_in, tmr3_in;
  int         n_errors = 0;
  int         cmp_count = 0;

  port_pin_function_select i_port_pin_function_select (
    .core_clk(core_clk), .nrst(nrst), .port_dir(cur.dir),
    .port_data(cur.dat), .sel_b2(cur.s2), .sel_b3(cur.s3), .sel_a0(cur.s0),
    .spi_master(cur.sp[4]), .spi_ss_n(cur.sp[3]),
    .spi_miso_out(cur.sp[2]), .spi_mosi_out(cur.sp[1]),
    .spi_miso_in(miso_in), .spi_mosi_in(mosi_in),
    .timer_channel_2_out(cur.tm[0]), .timer_channel_2_oe(cur.tm[1]),
    .timer_channel_3_out(cur.tm[2]), .timer_channel_3_oe(cur.tm[3]),
    .pulse_width_output_0(cur.sp[0]), .timer_channel_2_in(tmr2_in),
    .timer_channel_3_in(tmr3_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .port_in(port_in));
  spi_far_side i_spi_far_side (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_en(far_en), .ext_val(far_val), .pin_in(pin_in));

  always #2.5 core_clk = ~core_clk;

  task automatic chk(string what, logic [2:0] got, logic [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d of %0d checks", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // spi selects stand through reset; first edge out must still be port
  initial begin
    cur = rows[2];
    repeat (2) @(negedge core_clk);
    nrst = 1'h1;
    @(negedge core_clk);
    chk("reset oe", pin_oe, 3'h0);
    foreach (rows[i]) begin
      cur = rows[i];
      repeat (3) @(negedge core_clk);
      exp_in = (cur.oe & cur.out) | (~cur.oe & 3'h6);
      chk("pin_oe", pin_oe, cur.oe);
      chk("pin_out", pin_out & cur.oe, cur.out);
      chk("port_in", port_in, exp_in);
      chk("spi_in", {1'h0, mosi_in, miso_in}, exp_in & 3'h3);
      chk("timer_in", {1'h0, tmr3_in, tmr2_in}, exp_in & 3'h3);
    end
    // master mode: far slave drives miso high, then lets it float up
    cur = rows[4];
    far_val = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("master miso", {1'h0, mosi_in, miso_in}, 3'h3);
    far_en = 1'h0;
    far_val = 1'h0;
    repeat (2) @(negedge core_clk);
    chk("float miso", port_in, 3'h7);
    // reset in mid-run with peripherals still selected
    cur = rows[2];
    repeat (3) @(negedge core_clk);
    cur = rows[3];
    nrst = 1'h0;
    @(negedge core_clk);
    chk("rerun oe", pin_oe, 3'h0);
    chk("rerun in", port_in, 3'h0);
    chk("rerun spi", {1'h0, mosi_in, miso_in}, 3'h0);
    // release with spi selects held: port settings rule the first edge
    nrst = 1'h1;
    @(negedge core_clk);
    chk("release oe", pin_oe, cur.dir);
    chk("release out", pin_out, cur.dat);
    @(negedge core_clk);
    chk("select oe", pin_oe, cur.oe);
    test_done();
  end

  // run needs about 35 cycles; the limit allows 400
  initial begin
    #2000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
